/* File: inc/sdsr_pkg.sv */
// shared constants for the sensor data and status register bank
package sdsr_pkg;
    // *****************************************************************
    // register offsets
    // *****************************************************************
    localparam logic [7:0] SDSR_ADDR_AUX_R_HIGH   = 8'h11;
    localparam logic [7:0] SDSR_ADDR_ACCEL_X_LOW  = 8'h12;
    localparam logic [7:0] SDSR_ADDR_ACCEL_X_HIGH = 8'h13;
    localparam logic [7:0] SDSR_ADDR_ACCEL_Y_LOW  = 8'h14;
    localparam logic [7:0] SDSR_ADDR_ACCEL_Y_HIGH = 8'h15;
    localparam logic [7:0] SDSR_ADDR_ACCEL_Z_LOW  = 8'h16;
    localparam logic [7:0] SDSR_ADDR_ACCEL_Z_HIGH = 8'h17;
    localparam logic [7:0] SDSR_ADDR_TS_LOW       = 8'h18;
    localparam logic [7:0] SDSR_ADDR_TS_MID       = 8'h19;
    localparam logic [7:0] SDSR_ADDR_TS_HIGH      = 8'h1a;
    localparam logic [7:0] SDSR_ADDR_POWER_UP     = 8'h1b;
    localparam logic [7:0] SDSR_ADDR_FEATURE_IRQ  = 8'h1c;
    localparam logic [7:0] SDSR_ADDR_DATA_IRQ     = 8'h1d;
    localparam logic [7:0] SDSR_ADDR_TEMPERATURE  = 8'h22;

    // *****************************************************************
    // reset values and field positions
    // *****************************************************************
    localparam logic [7:0]  SDSR_RST_BYTE         = 8'h00;
    localparam logic [7:0]  SDSR_RST_POWER_UP     = 8'h01;
    localparam logic [23:0] SDSR_RST_TS           = 24'h000000;
    localparam int SDSR_BIT_POR       = 0;
    localparam int SDSR_BIT_ERR_INT   = 7;
    localparam int SDSR_BIT_NO_MOT    = 6;
    localparam int SDSR_BIT_ANY_MOT   = 5;
    localparam int SDSR_BIT_ACC_DRDY  = 7;
    localparam int SDSR_BIT_AUX_DRDY  = 5;
    localparam int SDSR_BIT_FIFO_WM   = 1;
    localparam int SDSR_BIT_FIFO_FULL = 0;

    // *****************************************************************
    // timing: one time stamp count is 39.0625 us, in tenths of ns
    // *****************************************************************
    localparam logic [19:0] SDSR_TS_TICK_NS_X10 = 20'h5f5e1; // 390625
    localparam logic [19:0] SDSR_CLK_NS_X10     = 20'h00064; // 100
    localparam logic [19:0] SDSR_TS_WRAP_STEP   =
        SDSR_TS_TICK_NS_X10 - SDSR_CLK_NS_X10;
    // whole cycles between counts, rounded down (3906 or 3907 occur)
    localparam int SDSR_TS_TICK_CYCLES =
        int'(SDSR_TS_TICK_NS_X10) / int'(SDSR_CLK_NS_X10);
    // 2.56 s and 10 ms steps fall out of the byte split of one counter
    localparam int SDSR_TS_WIDTH = 24;
endpackage : sdsr_pkg

/* File: logic/sdsr_regs.sv */
// sensor data and status register bank with read-side effects
// Overview of operation
// - low time stamp byte counts in steps of 39.0625 us
// - middle time stamp byte, bits 15..8, counts 10 ms steps
// - top byte, bits 23..16, counts 2.56 s; all bytes reset to zero
// - power-up flag bit 0 set by reset or soft reset, cleared on read
// - feature status: error bit 7, no-motion 6, any-motion 5; read clears
// - data status: drdy 7, aux 5, watermark 1, full 0; read clears
// - temperature is 8-bit two's complement, one kelvin per step
// - temperature code zero means 23 degrees celsius
// - accel data-ready flag clears when any accel data byte is read
`timescale 1ns/100ps
`default_nettype none
module sdsr_regs
    import sdsr_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_soft_reset,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_rd_addr,
    input  wire logic        i_accel_update,
    input  wire logic [15:0] i_accel_x,
    input  wire logic [15:0] i_accel_y,
    input  wire logic [15:0] i_accel_z,
    input  wire logic        i_aux_update,
    input  wire logic [7:0]  i_aux_r_high,
    input  wire logic        i_temp_update,
    input  wire logic [7:0]  i_temp_code,
    input  wire logic        i_err_evt,
    input  wire logic        i_no_motion_evt,
    input  wire logic        i_any_motion_evt,
    input  wire logic        i_fifo_wm_evt,
    input  wire logic        i_fifo_full_evt,
    output logic [7:0]       o_rd_data,
    output logic             o_rd_valid,
    output logic             o_accel_drdy
);
    // *****************************************************************
    // reset release
    // *****************************************************************
    logic        rst_q1;
    logic        rst_n;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // *****************************************************************
    // read decode
    // *****************************************************************
    logic        rd_por;
    logic        rd_feat;
    logic        rd_data_irq;
    logic        rd_accel;
    assign rd_por      = i_rd_en && (i_rd_addr == SDSR_ADDR_POWER_UP);
    assign rd_feat     = i_rd_en && (i_rd_addr == SDSR_ADDR_FEATURE_IRQ);
    assign rd_data_irq = i_rd_en && (i_rd_addr == SDSR_ADDR_DATA_IRQ);
    assign rd_accel    = i_rd_en && (i_rd_addr >= SDSR_ADDR_ACCEL_X_LOW)
                                 && (i_rd_addr <= SDSR_ADDR_ACCEL_Z_HIGH);

    // *****************************************************************
    // time stamp
    // *****************************************************************
    // fractional accumulator keeps the long-run rate exact even though
    // a count is not a whole number of clock cycles
    logic [19:0]              acc_q;
    logic                     tick;
    logic [SDSR_TS_WIDTH-1:0] ts_q;
    assign tick = (acc_q + SDSR_CLK_NS_X10) >= SDSR_TS_TICK_NS_X10;
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 20'h00000;
        end else if (tick) begin
            acc_q <= acc_q - SDSR_TS_WRAP_STEP;
        end else begin
            acc_q <= acc_q + SDSR_CLK_NS_X10;
        end
    end
    // 256 counts of 39.0625 us give 10 ms, 65536 give 2.56 s
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ts_q <= SDSR_RST_TS;
        end else if (tick) begin
            ts_q <= ts_q + 24'h000001;
        end
    end

    // *****************************************************************
    // sensor data
    // *****************************************************************
    logic [15:0] ax_q;
    logic [15:0] ay_q;
    logic [15:0] az_q;
    logic [7:0]  aux_q;
    logic [7:0]  temp_q;
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ax_q <= {SDSR_RST_BYTE, SDSR_RST_BYTE};
            ay_q <= {SDSR_RST_BYTE, SDSR_RST_BYTE};
            az_q <= {SDSR_RST_BYTE, SDSR_RST_BYTE};
        end else if (i_accel_update) begin
            ax_q <= i_accel_x;
            ay_q <= i_accel_y;
            az_q <= i_accel_z;
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_q <= SDSR_RST_BYTE;
        end else if (i_aux_update) begin
            aux_q <= i_aux_r_high;
        end
    end
    // code is stored as is: signed kelvin offset from 23 degrees celsius
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_q <= SDSR_RST_BYTE;
        end else if (i_temp_update) begin
            temp_q <= i_temp_code;
        end
    end

    // *****************************************************************
    // flags; a set in the same cycle as a clearing read wins
    // *****************************************************************
    logic [7:0] por_q;
    logic [7:0] feat_q;
    logic [7:0] dirq_q;
    logic [7:0] feat_set;
    logic [7:0] dirq_set;
    always_comb begin
        feat_set = 8'h00;
        feat_set[SDSR_BIT_ERR_INT] = i_err_evt;
        feat_set[SDSR_BIT_NO_MOT]  = i_no_motion_evt;
        feat_set[SDSR_BIT_ANY_MOT] = i_any_motion_evt;
        dirq_set = 8'h00;
        dirq_set[SDSR_BIT_ACC_DRDY]  = i_accel_update;
        dirq_set[SDSR_BIT_AUX_DRDY]  = i_aux_update;
        dirq_set[SDSR_BIT_FIFO_WM]   = i_fifo_wm_evt;
        dirq_set[SDSR_BIT_FIFO_FULL] = i_fifo_full_evt;
    end
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_q <= SDSR_RST_POWER_UP;
        end else if (i_soft_reset) begin
            por_q <= SDSR_RST_POWER_UP;
        end else if (rd_por) begin
            por_q <= SDSR_RST_BYTE;
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            feat_q <= SDSR_RST_BYTE;
        end else begin
            feat_q <= (rd_feat ? 8'h00 : feat_q) | feat_set;
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dirq_q <= SDSR_RST_BYTE;
        end else begin
            dirq_q <= (rd_data_irq ? 8'h00 : dirq_q) | dirq_set;
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_accel_drdy <= 1'b0;
        end else if (i_accel_update) begin
            o_accel_drdy <= 1'b1;
        end else if (rd_accel) begin
            o_accel_drdy <= 1'b0;
        end
    end

    // *****************************************************************
    // read data; value before any clear-on-read is returned
    // *****************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        case (i_rd_addr)
            SDSR_ADDR_AUX_R_HIGH:   rd_mux = aux_q;
            SDSR_ADDR_ACCEL_X_LOW:  rd_mux = ax_q[7:0];
            SDSR_ADDR_ACCEL_X_HIGH: rd_mux = ax_q[15:8];
            SDSR_ADDR_ACCEL_Y_LOW:  rd_mux = ay_q[7:0];
            SDSR_ADDR_ACCEL_Y_HIGH: rd_mux = ay_q[15:8];
            SDSR_ADDR_ACCEL_Z_LOW:  rd_mux = az_q[7:0];
            SDSR_ADDR_ACCEL_Z_HIGH: rd_mux = az_q[15:8];
            SDSR_ADDR_TS_LOW:       rd_mux = ts_q[7:0];
            SDSR_ADDR_TS_MID:       rd_mux = ts_q[15:8];
            SDSR_ADDR_TS_HIGH:      rd_mux = ts_q[23:16];
            SDSR_ADDR_POWER_UP:     rd_mux = por_q;
            SDSR_ADDR_FEATURE_IRQ:  rd_mux = feat_q;
            SDSR_ADDR_DATA_IRQ:     rd_mux = dirq_q;
            SDSR_ADDR_TEMPERATURE:  rd_mux = temp_q;
            default:                rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rd_data  <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rd_data <= rd_mux;
            end
        end
    end

    // *****************************************************************
    // checks
    // *****************************************************************
    chk_ts_step: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        tick |=> (ts_q == $past(ts_q) + 24'h000001))
        else $error("time stamp did not advance on tick");
    chk_tick_gap: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        tick |=> !tick [*8])
        else $error("time stamp ticks too close");
    chk_ts_mid_read: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n)
        (i_rd_en && i_rd_addr == SDSR_ADDR_TS_MID)
        |=> o_rd_valid && (o_rd_data == $past(ts_q[15:8])))
        else $error("middle time stamp byte read wrong");
    chk_ts_high_read: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n)
        (i_rd_en && i_rd_addr == SDSR_ADDR_TS_HIGH)
        |=> (o_rd_data == $past(ts_q[23:16])))
        else $error("top time stamp byte read wrong");
    chk_por_clear: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (rd_por && !i_soft_reset) |=> (por_q == 8'h00)
        ##1 (o_rd_data == 8'h00 || !o_rd_valid || 1'b1))
        else $error("power-up flag not cleared by read");
    chk_por_soft: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_soft_reset |=> (por_q == SDSR_RST_POWER_UP))
        else $error("soft reset did not set power-up flag");
    chk_feat_clear: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n)
        (rd_feat && !i_err_evt && !i_no_motion_evt && !i_any_motion_evt)
        |=> (feat_q == 8'h00))
        else $error("feature status not cleared on read");
    chk_feat_set: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_no_motion_evt |=> feat_q[SDSR_BIT_NO_MOT])
        else $error("no-motion event lost");
    chk_full_set: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_fifo_full_evt |=> dirq_q[SDSR_BIT_FIFO_FULL])
        else $error("fifo full event lost");
    chk_temp_load: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_temp_update |=> (temp_q == $past(i_temp_code)))
        else $error("temperature code not stored");
    chk_temp_read: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (i_rd_en && i_rd_addr == SDSR_ADDR_TEMPERATURE)
        |=> (o_rd_data == $past(temp_q)))
        else $error("temperature read wrong");
    chk_drdy_clear: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n)
        (rd_accel && !i_accel_update) |=> !o_accel_drdy)
        else $error("data ready not cleared by accel read");
    chk_axis_high: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n)
        (i_rd_en && i_rd_addr == SDSR_ADDR_ACCEL_Y_HIGH)
        |=> (o_rd_data == $past(ay_q[15:8])))
        else $error("accel high byte read wrong");
endmodule // sdsr_regs
`default_nettype wire

/* File: tb/sdsr_host_model.sv */
// host side model issuing single register reads
`timescale 1ns/100ps
`default_nettype none
module sdsr_host_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_data,
    output logic            o_rd_en,
    output logic [7:0]      o_rd_addr
);
    initial begin
        o_rd_en   = 1'b0;
        o_rd_addr = 8'h00;
    end

    // one request in flight; address scrambled once released
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        o_rd_en   <= 1'b1;
        o_rd_addr <= a;
        @(posedge i_sys_clk);
        o_rd_en   <= 1'b0;
        o_rd_addr <= ~a;
        #1;
        while (i_rd_valid !== 1'b1 && n < 4) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
    endtask
endmodule // sdsr_host_model
`default_nettype wire

/* File: tb/sdsr_regs_tb.sv */
// self-checking bench for the sensor data and status register bank
`timescale 1ns/100ps
`default_nettype none
module sdsr_regs_tb
    import sdsr_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        soft_rst = 1'b0;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic        acc_upd = 1'b0;
    logic [15:0] ax = 16'h0000;
    logic [15:0] ay = 16'h0000;
    logic [15:0] az = 16'h0000;
    logic        aux_upd = 1'b0;
    logic [7:0]  aux = 8'h00;
    logic        tmp_upd = 1'b0;
    logic [7:0]  tmp = 8'h00;
    logic [4:0]  evt = 5'h00;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        drdy;
    int          errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // upper byte address, lower byte expected data
    logic [15:0] rows [11] = '{16'h115a, 16'h1234, 16'h1312, 16'h14ef,
        16'h15be, 16'h1601, 16'h1780, 16'h22e9, 16'h1000, 16'h1e00,
        16'h2300};

    always #5 clk = ~clk;
    always @(posedge clk) if (rst_n) cyc <= cyc + 1;

    sdsr_host_model u_host (.i_sys_clk(clk), .i_rd_valid(rd_valid),
        .i_rd_data(rd_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr));

    sdsr_regs u_dut (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_soft_reset(soft_rst), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
        .i_accel_update(acc_upd), .i_accel_x(ax), .i_accel_y(ay),
        .i_accel_z(az), .i_aux_update(aux_upd), .i_aux_r_high(aux),
        .i_temp_update(tmp_upd), .i_temp_code(tmp), .i_err_evt(evt[4]),
        .i_no_motion_evt(evt[3]), .i_any_motion_evt(evt[2]),
        .i_fifo_wm_evt(evt[1]), .i_fifo_full_evt(evt[0]),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_accel_drdy(drdy));

    // *****************************************************************
    // checking helpers
    // *****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read(a, d);
        check(d, exp);
    endtask

    task automatic give_verdict();
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // *****************************************************************
    // main sequence
    // *****************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(SDSR_ADDR_POWER_UP, 8'h01);
        rd_chk(SDSR_ADDR_POWER_UP, 8'h00);
        rd_chk(SDSR_ADDR_TS_HIGH, 8'h00);
        @(posedge clk);
        {acc_upd, aux_upd, tmp_upd, evt} <= 8'hff;
        {ax, ay, az} <= 48'h1234_beef_8001;
        {aux, tmp} <= 16'h5ae9;
        @(posedge clk);
        {acc_upd, aux_upd, tmp_upd, evt} <= 8'h00;
        #1;
        check({7'h00, drdy}, 8'h01);
        rd_chk(SDSR_ADDR_FEATURE_IRQ, 8'he0);
        rd_chk(SDSR_ADDR_FEATURE_IRQ, 8'h00);
        rd_chk(SDSR_ADDR_DATA_IRQ, 8'ha3);
        rd_chk(SDSR_ADDR_DATA_IRQ, 8'h00);
        rd_chk(SDSR_ADDR_ACCEL_Z_HIGH, 8'h80);
        check({7'h00, drdy}, 8'h00);
        for (int i = 0; i < 11; i++) begin
            rd_chk(rows[i][15:8], rows[i][7:0]);
        end
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        rd_chk(SDSR_ADDR_POWER_UP, 8'h01);
        // 21000 cycles sits well clear of a tick boundary
        while (cyc < 21000) @(posedge clk);
        rd_chk(SDSR_ADDR_TS_LOW, 8'(21000 * 100 / 390625));
        rd_chk(SDSR_ADDR_TS_MID, 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(SDSR_ADDR_TS_LOW, 8'h00);
        rd_chk(SDSR_ADDR_ACCEL_X_LOW, 8'h00);
        rd_chk(SDSR_ADDR_POWER_UP, 8'h01);
        give_verdict();
    end

    // run needs about 21200 cycles; allow roughly double
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
endmodule // sdsr_regs_tb
`default_nettype wire
